// ### include/twa_params.svh
`ifndef TWA_PARAMS_SVH
`define TWA_PARAMS_SVH

// APB address width and word-index decode
`define TWA_ADDR_W        8
`define TWA_IDX_MSB       7
`define TWA_IDX_LSB       2
`define TWA_IDX_W         6

// Register indices; byte address is four times the index
`define TWA_IDX_TEMP      6'h00
`define TWA_IDX_CFG       6'h01
`define TWA_IDX_HYST      6'h02
`define TWA_IDX_CRIT      6'h03
`define TWA_IDX_LOW       6'h04
`define TWA_IDX_HIGH      6'h05
`define TWA_IDX_IRQ_STAT  6'h06
`define TWA_IDX_IRQ_MASK  6'h07

// Configuration register bits
`define TWA_CFG_SHDN      0
`define TWA_CFG_MODE      1
`define TWA_CFG_CPOL      2
`define TWA_CFG_WPOL      3
`define TWA_CFG_FQ        4
`define TWA_CFG_W         5

// Temperature and limit field inside a 16-bit word
`define TWA_LIM_MSB       15
`define TWA_LIM_LSB       3
`define TWA_FLAG_MSB      2

// Status flag positions (also comparator index)
`define TWA_ST_LOW        0
`define TWA_ST_HIGH       1
`define TWA_ST_CRIT       2
`define TWA_ST_W          3

// Interrupt status bits
`define TWA_IRQ_WIN       0
`define TWA_IRQ_CRIT      1
`define TWA_IRQ_SMP       2
`define TWA_IRQ_W         3

// Reset values of the limit fields, 13-bit two's complement
`define TWA_RST_HYST      13'h0020
`define TWA_RST_CRIT      13'h0700
`define TWA_RST_LOW       13'h0000
`define TWA_RST_HIGH      13'h0600

// Consecutive samples needed to change a flag
`define TWA_FQ_OFF        1
`define TWA_FQ_ON         4

`endif

// ### include/twa_pkg.sv
package twa_pkg;

  // Temperature in 1/16 degree steps, two's complement
  typedef logic signed [12:0] twa_temp_t;

  // Which side of a limit counts as a fault
  typedef enum logic {
    TWA_BELOW = 1'b0,
    TWA_ABOVE = 1'b1
  } twa_dir_t;

endpackage : twa_pkg

// ### logic/twa_cmp.sv
`timescale 1ns/1ps
`include "twa_params.svh"

module twa_cmp #(
  parameter int QW = 3
) (
  // Clock and reset
  input  logic               clk,
  input  logic               rst_n,
  // Control
  input  logic               sample,
  input  logic               clear,
  input  twa_pkg::twa_dir_t  dir,
  input  logic [QW-1:0]      need,
  // Data
  input  twa_pkg::twa_temp_t temp,
  input  twa_pkg::twa_temp_t trip_lim,
  input  twa_pkg::twa_temp_t hyst,
  // Result
  output logic               flag_q
);
  import twa_pkg::*;

  logic signed [13:0] t_x;
  logic signed [13:0] trip_x;
  logic signed [13:0] hyst_x;
  logic signed [13:0] rel_x;
  logic               raw_trip;
  logic               raw_rel;
  logic               pend;
  logic [QW-1:0]      cnt_q;
  logic [QW-1:0]      cnt_inc;

  // One extra bit so limit plus hysteresis cannot wrap
  assign t_x    = {temp[12], temp};
  assign trip_x = {trip_lim[12], trip_lim};
  assign hyst_x = {hyst[12], hyst};
  assign rel_x  = (dir == TWA_ABOVE) ? (trip_x - hyst_x) : (trip_x + hyst_x);

  assign raw_trip = (dir == TWA_ABOVE) ? (t_x > trip_x) : (t_x < trip_x);
  assign raw_rel  = (dir == TWA_ABOVE) ? (t_x < rel_x) : (t_x > rel_x);
  assign pend     = flag_q ? raw_rel : raw_trip;
  assign cnt_inc  = cnt_q + {{(QW-1){1'b0}}, 1'b1};

  // Apart from clear, a flag changes only after enough consecutive samples agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      cnt_q  <= '0;
    end else if (clear) begin
      flag_q <= 1'b0;
      cnt_q  <= '0;
    end else if (sample) begin
      if (pend) begin
        if (cnt_inc >= need) begin
          flag_q <= ~flag_q;
          cnt_q  <= '0;
        end else begin
          cnt_q <= cnt_inc;
        end
      end else begin
        cnt_q <= '0;
      end
    end
  end

endmodule : twa_cmp

// ### logic/twa_alert.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "twa_params.svh"

// What this block does
// - The window alert goes active when the temperature rises above the upper window limit.
// - The window alert goes active when the temperature falls below the lower window limit.
// - Readable status flags show which limit (low, high, critical) was crossed.
// - In event mode a further alert is issued when the temperature comes back inside the window.
// - In comparator mode the window alert drops once the temperature is back inside the window by more than the hysteresis.
// - In event mode an asserted alert stays active until the host reads the device.
// - Crossing the critical limit drives the critical alarm output, separate from the window alert.
// - In event mode any host read clears the window alert, except a read in the same cycle as a new window event.
// - Shutdown returns both alert outputs to their inactive level.
// - A configuration bit selects comparator mode at 0 and event mode at 1.
// - Each alert output has its own polarity bit, 0 for active low and 1 for active high.
module twa_alert #(
  parameter int QW = 3
) (
  // Clock and reset
  input  logic                   SYS_CLK,
  input  logic                   RST_N,
  // APB slave
  input  logic                   PSEL,
  input  logic                   PENABLE,
  input  logic                   PWRITE,
  input  logic [`TWA_ADDR_W-1:0] PADDR,
  input  logic [31:0]            PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Conversion result
  input  twa_pkg::twa_temp_t     TEMP_IN,
  input  logic                   TEMP_VALID,
  // Alert outputs
  output logic                   WIN_ALERT,
  output logic                   CRITICAL_ALARM_OUTPUT,
  output logic                   IRQ
);
  import twa_pkg::*;

  // Configuration
  logic                   cfg_shdn_q;
  logic                   cfg_mode_q;
  logic                   cfg_cpol_q;
  logic                   cfg_wpol_q;
  logic                   cfg_fq_q;

  // Limits and sample
  twa_temp_t              hyst_q;
  twa_temp_t              critical_limit_q;
  twa_temp_t              low_q;
  twa_temp_t              high_q;
  twa_temp_t              temp_q;

  // Comparator state
  logic [`TWA_ST_W-1:0]   flags;
  logic [`TWA_ST_W-1:0]   flags_d1_q;
  twa_temp_t              lim_sel [`TWA_ST_W];
  twa_dir_t               dir_sel [`TWA_ST_W];
  logic [QW-1:0]          need;
  logic                   smp;
  logic                   win_chg;
  logic                   evt_q;
  logic                   win_act;
  logic                   crit_act;
  logic                   win_act_q;
  logic                   crit_act_q;

  // Interrupt state
  logic [`TWA_IRQ_W-1:0]  stat_q;
  logic [`TWA_IRQ_W-1:0]  stat_d;
  logic [`TWA_IRQ_W-1:0]  stat_set;
  logic [`TWA_IRQ_W-1:0]  mask_q;

  // Output flops
  logic                   win_out_q;
  logic                   crit_out_q;
  logic                   irq_q;

  // APB state
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;
  logic                   rd_stat_q;
  logic                   setup;
  logic                   access;
  logic                   wr;
  logic                   rd;
  logic [`TWA_IDX_W-1:0]  idx;
  logic                   hit;
  logic [31:0]            rd_mux;

  assign PRDATA                = prdata_q;
  assign PREADY                = pready_q;
  assign PSLVERR               = pslverr_q;
  assign WIN_ALERT             = win_out_q;
  assign CRITICAL_ALARM_OUTPUT = crit_out_q;
  assign IRQ                   = irq_q;

  // ---------------- APB slave ----------------

  assign setup  = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & pready_q;
  assign wr     = access & PWRITE;
  assign rd     = access & ~PWRITE;
  assign idx    = PADDR[`TWA_IDX_MSB:`TWA_IDX_LSB];

  // Address decode and read mux; unaligned or unknown addresses miss
  always_comb begin
    hit    = (PADDR[`TWA_IDX_LSB-1:0] == '0);
    rd_mux = 32'h0000_0000;
    case (idx)
      `TWA_IDX_TEMP: begin
        rd_mux[`TWA_LIM_MSB:`TWA_LIM_LSB] = temp_q;
        rd_mux[`TWA_FLAG_MSB:0]           = flags;
      end
      `TWA_IDX_CFG: begin
        rd_mux[`TWA_CFG_SHDN] = cfg_shdn_q;
        rd_mux[`TWA_CFG_MODE] = cfg_mode_q;
        rd_mux[`TWA_CFG_CPOL] = cfg_cpol_q;
        rd_mux[`TWA_CFG_WPOL] = cfg_wpol_q;
        rd_mux[`TWA_CFG_FQ]   = cfg_fq_q;
      end
      `TWA_IDX_HYST: begin
        rd_mux[`TWA_LIM_MSB:`TWA_LIM_LSB] = hyst_q;
      end
      `TWA_IDX_CRIT: begin
        rd_mux[`TWA_LIM_MSB:`TWA_LIM_LSB] = critical_limit_q;
      end
      `TWA_IDX_LOW: begin
        rd_mux[`TWA_LIM_MSB:`TWA_LIM_LSB] = low_q;
      end
      `TWA_IDX_HIGH: begin
        rd_mux[`TWA_LIM_MSB:`TWA_LIM_LSB] = high_q;
      end
      `TWA_IDX_IRQ_STAT: begin
        rd_mux[`TWA_IRQ_W-1:0] = stat_q;
      end
      `TWA_IDX_IRQ_MASK: begin
        rd_mux[`TWA_IRQ_W-1:0] = mask_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // One wait-free access phase: PREADY rises in the cycle after setup
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      rd_stat_q <= 1'b0;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~hit;
      prdata_q  <= (PWRITE || !hit) ? 32'h0000_0000 : rd_mux;
      rd_stat_q <= ~PWRITE & hit & (idx == `TWA_IDX_IRQ_STAT);
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rd_stat_q <= 1'b0;
    end
  end

  // Register writes; the temperature word is read only and ignores writes
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_shdn_q       <= 1'b0;
      cfg_mode_q       <= 1'b0;
      cfg_cpol_q       <= 1'b0;
      cfg_wpol_q       <= 1'b0;
      cfg_fq_q         <= 1'b0;
      hyst_q           <= `TWA_RST_HYST;
      critical_limit_q <= `TWA_RST_CRIT;
      low_q            <= `TWA_RST_LOW;
      high_q           <= `TWA_RST_HIGH;
      mask_q           <= '0;
    end else if (wr && hit) begin
      case (idx)
        `TWA_IDX_CFG: begin
          cfg_shdn_q <= PWDATA[`TWA_CFG_SHDN];
          cfg_mode_q <= PWDATA[`TWA_CFG_MODE];
          cfg_cpol_q <= PWDATA[`TWA_CFG_CPOL];
          cfg_wpol_q <= PWDATA[`TWA_CFG_WPOL];
          cfg_fq_q   <= PWDATA[`TWA_CFG_FQ];
        end
        `TWA_IDX_HYST: begin
          hyst_q <= PWDATA[`TWA_LIM_MSB:`TWA_LIM_LSB];
        end
        `TWA_IDX_CRIT: begin
          critical_limit_q <= PWDATA[`TWA_LIM_MSB:`TWA_LIM_LSB];
        end
        `TWA_IDX_LOW: begin
          low_q <= PWDATA[`TWA_LIM_MSB:`TWA_LIM_LSB];
        end
        `TWA_IDX_HIGH: begin
          high_q <= PWDATA[`TWA_LIM_MSB:`TWA_LIM_LSB];
        end
        `TWA_IDX_IRQ_MASK: begin
          mask_q <= PWDATA[`TWA_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- Sampling and comparators ----------------

  // No new results are taken while shut down
  assign smp  = TEMP_VALID & ~cfg_shdn_q;
  assign need = cfg_fq_q ? QW'(`TWA_FQ_ON) : QW'(`TWA_FQ_OFF);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      temp_q <= '0;
    end else if (smp) begin
      temp_q <= TEMP_IN;
    end
  end

  assign lim_sel[`TWA_ST_LOW]  = low_q;
  assign lim_sel[`TWA_ST_HIGH] = high_q;
  assign lim_sel[`TWA_ST_CRIT] = critical_limit_q;
  assign dir_sel[`TWA_ST_LOW]  = TWA_BELOW;
  assign dir_sel[`TWA_ST_HIGH] = TWA_ABOVE;
  assign dir_sel[`TWA_ST_CRIT] = TWA_ABOVE;

  // Limits act at the next sample, so reprogramming is seen on the next result
  for (genvar i = 0; i < `TWA_ST_W; i++) begin : g_cmp
    twa_cmp #(
      .QW (QW)
    ) u_cmp (
      .clk      (SYS_CLK),
      .rst_n    (RST_N),
      .sample   (smp),
      .clear    (cfg_shdn_q),
      .dir      (dir_sel[i]),
      .need     (need),
      .temp     (TEMP_IN),
      .trip_lim (lim_sel[i]),
      .hyst     (hyst_q),
      .flag_q   (flags[i])
    );
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_d1_q <= '0;
    end else begin
      flags_d1_q <= flags;
    end
  end

  // Any change of the window flags is an event: leaving or re-entering
  assign win_chg = (flags[`TWA_ST_HIGH] != flags_d1_q[`TWA_ST_HIGH]) |
                   (flags[`TWA_ST_LOW] != flags_d1_q[`TWA_ST_LOW]);

  // Event latch; a new event wins over a read in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_q <= 1'b0;
    end else if (cfg_shdn_q || !cfg_mode_q) begin
      evt_q <= 1'b0;
    end else if (win_chg) begin
      evt_q <= 1'b1;
    end else if (rd) begin
      evt_q <= 1'b0;
    end
  end

  // ---------------- Alert outputs ----------------

  always_comb begin
    if (cfg_shdn_q) begin
      win_act  = 1'b0;
      crit_act = 1'b0;
    end else begin
      win_act  = cfg_mode_q ? evt_q : (flags[`TWA_ST_HIGH] | flags[`TWA_ST_LOW]);
      crit_act = flags[`TWA_ST_CRIT];
    end
  end

  // Reset level is high: inactive for the default active-low polarity
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_out_q  <= 1'b1;
      crit_out_q <= 1'b1;
    end else begin
      win_out_q  <= cfg_wpol_q ? win_act : ~win_act;
      crit_out_q <= cfg_cpol_q ? crit_act : ~crit_act;
    end
  end

  // ---------------- Interrupt ----------------

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_act_q  <= 1'b0;
      crit_act_q <= 1'b0;
    end else begin
      win_act_q  <= win_act;
      crit_act_q <= crit_act;
    end
  end

  always_comb begin
    stat_set                = '0;
    stat_set[`TWA_IRQ_WIN]  = win_act & ~win_act_q;
    stat_set[`TWA_IRQ_CRIT] = crit_act & ~crit_act_q;
    stat_set[`TWA_IRQ_SMP]  = smp;
    stat_d                  = stat_q;
    // Only bits returned by the read are cleared, so a set after setup survives
    if (rd && rd_stat_q) begin
      stat_d = stat_q & ~prdata_q[`TWA_IRQ_W-1:0];
    end
    stat_d = stat_d | stat_set;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & mask_q);
    end
  end

endmodule : twa_alert

// ### tb/twa_alert_checker.sv
`timescale 1ns/1ps
`include "twa_params.svh"
module twa_alert_checker #(
  parameter int QW = 3
) (
  // Clock and reset
  input logic                   SYS_CLK,
  input logic                   RST_N,
  // APB
  input logic                   PSEL,
  input logic                   PENABLE,
  input logic                   PWRITE,
  input logic [`TWA_ADDR_W-1:0] PADDR,
  input logic [31:0]            PWDATA,
  input logic                   PREADY,
  // Samples and alerts
  input twa_pkg::twa_temp_t     TEMP_IN,
  input logic                   TEMP_VALID,
  input logic                   WIN_ALERT,
  input logic                   CRITICAL_ALARM_OUTPUT
);
  import twa_pkg::*;
  logic [4:0] cfg_q;
  twa_temp_t  hi_q, lo_q, hy_q, cr_q;
  wire wr     = PSEL && PENABLE && PREADY && PWRITE;
  wire rd     = PSEL && PENABLE && PREADY && !PWRITE;
  wire win_on = WIN_ALERT == cfg_q[3];
  // Shadow of the settings so the alert levels can be predicted
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= 5'h00;
      hy_q  <= `TWA_RST_HYST;
      cr_q  <= `TWA_RST_CRIT;
      lo_q  <= `TWA_RST_LOW;
      hi_q  <= `TWA_RST_HIGH;
    end else if (wr) begin
      case (PADDR)
        8'h04: cfg_q <= PWDATA[4:0];
        8'h08: hy_q <= PWDATA[15:3];
        8'h0C: cr_q <= PWDATA[15:3];
        8'h10: lo_q <= PWDATA[15:3];
        8'h14: hi_q <= PWDATA[15:3];
        default: ;
      endcase
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  win_high_a: assert property (
    TEMP_VALID && cfg_q[1:0] == 2'h0 && !cfg_q[4] && TEMP_IN > hi_q |-> ##2 win_on) else $error("no alert above");
  win_low_a: assert property (
    TEMP_VALID && cfg_q[1:0] == 2'h0 && !cfg_q[4] && TEMP_IN < lo_q |-> ##2 win_on) else $error("no alert below");
  win_clear_a: assert property (
    TEMP_VALID && cfg_q[1:0] == 2'h0 && !cfg_q[4] && TEMP_IN < hi_q - hy_q && TEMP_IN > lo_q + hy_q
    |-> ##2 !win_on) else $error("alert inside window");
  crit_on_a: assert property (
    TEMP_VALID && !cfg_q[0] && !cfg_q[4] && TEMP_IN > cr_q |-> ##2 CRITICAL_ALARM_OUTPUT == cfg_q[2])
    else $error("no critical alarm");
  evt_hold_a: assert property (
    cfg_q[1:0] == 2'h2 && $stable(cfg_q) && win_on && !wr && !rd && !$past(rd) |=> win_on)
    else $error("event alert dropped without read");
  evt_clear_a: assert property (
    rd && cfg_q[1:0] == 2'h2 && !$past(TEMP_VALID) |-> ##2 !win_on) else $error("read left event alert");
  shdn_quiet_a: assert property (
    cfg_q[0] && $past(cfg_q[0]) && $stable(cfg_q) |-> !win_on && CRITICAL_ALARM_OUTPUT != cfg_q[2])
    else $error("alert active in shutdown");
  cover property (TEMP_VALID && TEMP_IN > cr_q);
  cover property (rd && cfg_q[1] && win_on);
  cover property (cfg_q[0] && TEMP_VALID);
endmodule : twa_alert_checker

bind twa_alert twa_alert_checker #(.QW(QW)) twa_alert_checker_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .TEMP_IN(TEMP_IN), .TEMP_VALID(TEMP_VALID), .WIN_ALERT(WIN_ALERT),
  .CRITICAL_ALARM_OUTPUT(CRITICAL_ALARM_OUTPUT));

// ### tb/twa_host.sv
`timescale 1ns/1ps
module twa_host (
  // Clock
  input  logic        clk,
  // APB master
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  initial begin
    psel    <= 1'h0;
    penable <= 1'h0;
    pwrite  <= 1'h0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
  end
  // Request stands until the rising edge that samples pready high; no cycle count is assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    // Released write data shows the inverse so a stale bus is not taken for a held one
    psel    <= 1'h0;
    penable <= 1'h0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : twa_host

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "twa_params.svh"
module tb_top;
  import twa_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, temp_valid, win, crit, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  twa_temp_t   temp_in;
  int          err_count, tests_run;

  twa_alert twa_alert_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TEMP_IN(temp_in), .TEMP_VALID(temp_valid), .WIN_ALERT(win),
    .CRITICAL_ALARM_OUTPUT(crit), .IRQ(irq));
  twa_host twa_host_inst (.clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    twa_host_inst.xfer(1'h1, a, d, r, e);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    twa_host_inst.xfer(1'h0, a, 32'h0, r, e);
    chk(n, r, x);
  endtask : rd
  task automatic tp(input twa_temp_t t);
    @(posedge sys_clk);
    temp_in    <= t;
    temp_valid <= 1'h1;
    @(posedge sys_clk);
    temp_valid <= 1'h0;
  endtask : tp
  task automatic ck(input string n, input logic w, input logic c);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({n, " win"}, {31'h0, win}, {31'h0, w});
    chk({n, " crit"}, {31'h0, crit}, {31'h0, c});
  endtask : ck
  task automatic ci(input logic x);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", {31'h0, irq}, {31'h0, x});
  endtask : ci
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    rst_n <= 1'h0;
    temp_in <= 13'h0000;
    temp_valid <= 1'h0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    ck("reset", 1'h1, 1'h1);
    rd("cfg", 8'h04, 32'h0);
    rd("high", 8'h14, {16'h0, `TWA_RST_HIGH, 3'h0});
    rd("crit lim", 8'h0C, {16'h0, `TWA_RST_CRIT, 3'h0});
    rd("hyst", 8'h08, {16'h0, `TWA_RST_HYST, 3'h0});
    twa_host_inst.xfer(1'h0, 8'h20, 32'h0, r, e);
    chk("miss", {31'h0, e}, 32'h1);
    wr(8'h00, 32'hFFFF);
    rd("temp ro", 8'h00, 32'h0);
    $display("test reset done");
    tp(13'h0640);
    ck("hot", 1'h0, 1'h1);
    ci(1'h0);
    wr(8'h1C, 32'h1);
    ci(1'h1);
    rd("temp hot", 8'h00, {16'h0, 13'h0640, 3'h2});
    rd("stat", 8'h18, 32'h5);
    ci(1'h0);
    wr(8'h14, {16'h0, 13'h0680, 3'h0});
    wr(8'h10, {16'h0, 13'h0600, 3'h0});
    tp(13'h0640);
    ck("inside", 1'h1, 1'h1);
    tp(13'h05C0);
    ck("cold", 1'h0, 1'h1);
    rd("temp cold", 8'h00, {16'h0, 13'h05C0, 3'h1});
    $display("test comparator done");
    wr(8'h04, 32'h4);
    tp(13'h0720);
    ck("crit", 1'h0, 1'h1);
    rd("temp crit", 8'h00, {16'h0, 13'h0720, 3'h6});
    tp(13'h0640);
    ck("cool", 1'h1, 1'h0);
    $display("test critical done");
    wr(8'h04, 32'hA);
    tp(13'h0690);
    ck("evt up", 1'h1, 1'h1);
    ck("evt hold", 1'h1, 1'h1);
    rd("temp evt", 8'h00, {16'h0, 13'h0690, 3'h2});
    ck("evt read", 1'h0, 1'h1);
    wr(8'h14, {16'h0, 13'h0700, 3'h0});
    tp(13'h0690);
    ck("evt back", 1'h1, 1'h1);
    rd("stat back", 8'h18, 32'h7);
    ck("evt read2", 1'h0, 1'h1);
    $display("test event done");
    tp(13'h0720);
    ck("pre shdn", 1'h1, 1'h0);
    wr(8'h04, 32'hB);
    ck("shdn", 1'h0, 1'h1);
    tp(13'h0720);
    ck("shdn ignore", 1'h0, 1'h1);
    $display("test shutdown done");
    // Fault queue on, comparator mode, both outputs active low
    wr(8'h04, 32'h10);
    repeat (3) tp(13'h0720);
    ck("fq three", 1'h1, 1'h1);
    tp(13'h0720);
    ck("fq four", 1'h0, 1'h0);
    $display("test fault queue done");
    print_verdict();
  end
endmodule : tb_top
